// ### flash_seq_pkg.sv
package flash_seq_pkg;
   // special register selects on the core-side register port
   localparam logic [3:0] SEL_FLASH_COMMAND = 4'h0;
   localparam logic [3:0] SEL_FLASH_STATUS = 4'h1;
   localparam logic [3:0] SEL_PROTECT_UNLOCK = 4'h2;
   localparam logic [3:0] SEL_MODE_CONTROL = 4'h3;
   localparam logic [3:0] SEL_ADDR_HIGH = 4'h4;
   localparam logic [3:0] SEL_ADDR_LOW = 4'h5;
   localparam logic [3:0] SEL_ADDR_HIGH_CMP = 4'h6;
   localparam logic [3:0] SEL_ADDR_LOW_CMP = 4'h7;
   localparam logic [3:0] SEL_WATCHDOG = 4'h8;
   // unlock and command codes
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam logic [7:0] MODE_NORMAL = 8'h00;
   localparam logic [7:0] MODE_SELF_PROG = 8'h01;
   localparam logic [7:0] CMD_NONE = 8'h00;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h03;
   localparam logic [7:0] CMD_BLANK_CHECK = 8'h04;
   localparam logic [7:0] WATCHDOG_RESTART = 8'hAC;
   localparam logic [7:0] LOW_CMP_ERASE = 8'h00;
   localparam logic [7:0] LOW_CMP_BLANK = 8'hFF;
   // flash status bits
   localparam int STATUS_UNLOCK_BIT = 0;
   localparam int STATUS_EXEC_BIT = 1;
   localparam int STATUS_PROTECT_BIT = 2;
   localparam int RETRY_BUDGET = 48;
   // controller APB map (byte addresses)
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_BLOCK = 8'h08;
   localparam logic [7:0] APB_RESULT = 8'h0C;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WDT_BIT = 1;
   localparam logic [1:0] OP_ENTER = 2'h0;
   localparam logic [1:0] OP_LEAVE = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] OP_BLANK = 2'h3;
   // device timing in cycles
   localparam int ERASE_CYCLES = 64;
   localparam int BLANK_CYCLES = 32;
   typedef enum logic [1:0] {
      UNLOCK_IDLE = 2'b00,
      UNLOCK_KEYED = 2'b01,
      UNLOCK_VALUE = 2'b10,
      UNLOCK_INVERSE = 2'b11
   } unlock_state_type;
endpackage

// ### flash_core_if.sv
`timescale 1ns/1ps
interface flash_core_if;
   logic wr_en;
   logic [3:0] sel;
   logic [7:0] wdata;
   logic [7:0] status;
   logic self_prog;
   logic halt_req;
   logic halt_ack;
   modport device(input wr_en, input sel, input wdata, input halt_req,
      output status, output self_prog, output halt_ack);
   modport core(output wr_en, output sel, output wdata, output halt_req,
      input status, input self_prog, input halt_ack);
endinterface

// ### flash_busy_timer.sv
`timescale 1ns/1ps
module flash_busy_timer #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic done
);
   logic [WIDTH-1:0] cnt_reg;
   logic run_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= count;
         run_reg <= 1'b1;
      end else if (run_reg && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end else begin
         run_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else begin
         done <= run_reg && cnt_reg == '0 && !load;
      end
   end
endmodule

// ### flash_sequencer.sv
`timescale 1ns/1ps
// Operation
// - software clears command before leaving mode
// - four ordered writes return to normal
// - only the third mode write applies
// - bit 0 flags failed unlock; retry
// - command 03H is block erase
// - erase: block in high, low zero
// - command 04H is blank check
// - blank check: low compare is FFH
// - clear status before starting command
// - write ACH to watchdog before start; the controller writes it only when CTRL_WDT_BIT is set
// - halt starts command; resume when done
// - bit 1 execution error, bit 2 protect
// - erase retried up to budget
// - protected erase sets protect bit
// - zero status means normal termination
// - code runs from untouched flash area
// - restore clock and masks after return; no clock or mask logic is modelled here
// - entry uses same pattern with 01H
module flash_sequencer #(
   parameter int BLOCKS = 32,
   parameter logic [7:0] PROTECT_BELOW = 8'h00,
   parameter logic [BLOCKS-1:0] NOT_BLANK = '0,
   parameter logic [BLOCKS-1:0] ERASE_FAIL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   flash_core_if.device core,
   output logic watchdog_restart,
   output logic erase_strobe,
   output logic [7:0] erase_block
);
   flash_seq_pkg::unlock_state_type unlock_reg;
   logic [7:0] mode_value_reg;
   logic self_prog_reg;
   logic [7:0] command_reg;
   logic [7:0] status_reg;
   logic [7:0] addr_high_reg;
   logic [7:0] addr_low_reg;
   logic [7:0] addr_high_cmp_reg;
   logic [7:0] addr_low_cmp_reg;
   logic busy_reg;
   logic halt_ack_reg;
   logic timer_done;
   logic timer_load;
   logic [7:0] timer_count;
   logic [2:0] result_bits;
   logic wr_mode;
   logic wr_status;

   assign wr_mode = core.wr_en && core.sel == flash_seq_pkg::SEL_MODE_CONTROL;
   assign wr_status = core.wr_en && core.sel == flash_seq_pkg::SEL_FLASH_STATUS;
   // a halt with a known command in self mode starts work; others just ack
   assign timer_load = core.halt_req && !busy_reg && !halt_ack_reg;
   assign timer_count = (self_prog_reg && command_reg == flash_seq_pkg::CMD_BLOCK_ERASE) ?
      8'(flash_seq_pkg::ERASE_CYCLES) :
      (self_prog_reg && command_reg == flash_seq_pkg::CMD_BLANK_CHECK) ?
      8'(flash_seq_pkg::BLANK_CYCLES) : 8'h01;

   flash_busy_timer #(.WIDTH(8)) flash_busy_timer_inst (
      .pclk(pclk),
      .presetn(presetn),
      .load(timer_load),
      .count(timer_count),
      .done(timer_done)
   );

   // unlock sequence tracker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_reg <= flash_seq_pkg::UNLOCK_IDLE;
         mode_value_reg <= 8'h00;
      end else if (core.wr_en) begin
         case (unlock_reg)
            flash_seq_pkg::UNLOCK_IDLE: begin
               if (core.sel == flash_seq_pkg::SEL_PROTECT_UNLOCK &&
                   core.wdata == flash_seq_pkg::UNLOCK_KEY) begin
                  unlock_reg <= flash_seq_pkg::UNLOCK_KEYED;
               end
            end
            flash_seq_pkg::UNLOCK_KEYED: begin
               mode_value_reg <= core.wdata;
               // first mode write is ignored, only remembered
               unlock_reg <= wr_mode ? flash_seq_pkg::UNLOCK_VALUE :
                  flash_seq_pkg::UNLOCK_IDLE;
            end
            flash_seq_pkg::UNLOCK_VALUE: begin
               unlock_reg <= (wr_mode && core.wdata == ~mode_value_reg) ?
                  flash_seq_pkg::UNLOCK_INVERSE : flash_seq_pkg::UNLOCK_IDLE;
            end
            flash_seq_pkg::UNLOCK_INVERSE: begin
               unlock_reg <= flash_seq_pkg::UNLOCK_IDLE;
            end
            default: begin
               unlock_reg <= flash_seq_pkg::UNLOCK_IDLE;
            end
         endcase
      end
   end

   // mode applies only on a clean third write of a legal value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         self_prog_reg <= 1'b0;
      end else if (core.wr_en && unlock_reg == flash_seq_pkg::UNLOCK_INVERSE && wr_mode &&
                   core.wdata == mode_value_reg) begin
         if (core.wdata == flash_seq_pkg::MODE_SELF_PROG) begin
            self_prog_reg <= 1'b1;
         end else if (core.wdata == flash_seq_pkg::MODE_NORMAL) begin
            self_prog_reg <= 1'b0;
         end
      end
   end

   // plain registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_reg <= 8'h00;
         addr_high_reg <= 8'h00;
         addr_low_reg <= 8'h00;
         addr_high_cmp_reg <= 8'h00;
         addr_low_cmp_reg <= 8'h00;
         watchdog_restart <= 1'b0;
      end else begin
         watchdog_restart <= core.wr_en && core.sel == flash_seq_pkg::SEL_WATCHDOG &&
            core.wdata == flash_seq_pkg::WATCHDOG_RESTART;
         if (core.wr_en) begin
            case (core.sel)
               flash_seq_pkg::SEL_FLASH_COMMAND: command_reg <= core.wdata;
               flash_seq_pkg::SEL_ADDR_HIGH: addr_high_reg <= core.wdata;
               flash_seq_pkg::SEL_ADDR_LOW: addr_low_reg <= core.wdata;
               flash_seq_pkg::SEL_ADDR_HIGH_CMP: addr_high_cmp_reg <= core.wdata;
               flash_seq_pkg::SEL_ADDR_LOW_CMP: addr_low_cmp_reg <= core.wdata;
               default: begin
               end
            endcase
         end
      end
   end

   // command outcome, evaluated when the timer finishes
   always_comb begin
      result_bits = 3'b000;
      if (self_prog_reg && command_reg == flash_seq_pkg::CMD_BLOCK_ERASE) begin
         if (addr_high_reg < PROTECT_BELOW) begin
            result_bits[flash_seq_pkg::STATUS_PROTECT_BIT] = 1'b1;
         end else if (addr_high_reg != addr_high_cmp_reg ||
                      addr_low_reg != flash_seq_pkg::LOW_CMP_ERASE ||
                      addr_low_cmp_reg != flash_seq_pkg::LOW_CMP_ERASE ||
                      addr_high_reg >= 8'(BLOCKS) || ERASE_FAIL[addr_high_reg[4:0]]) begin
            result_bits[flash_seq_pkg::STATUS_EXEC_BIT] = 1'b1;
         end
      end else if (self_prog_reg && command_reg == flash_seq_pkg::CMD_BLANK_CHECK) begin
         if (addr_high_reg != addr_high_cmp_reg ||
             addr_low_reg != flash_seq_pkg::LOW_CMP_ERASE ||
             addr_low_cmp_reg != flash_seq_pkg::LOW_CMP_BLANK ||
             addr_high_reg >= 8'(BLOCKS) || NOT_BLANK[addr_high_reg[4:0]]) begin
            result_bits[flash_seq_pkg::STATUS_EXEC_BIT] = 1'b1;
         end
      end
   end

   // status: hardware sets win over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 8'h00;
      end else begin
         status_reg <= (wr_status ? core.wdata : status_reg) |
            {5'b00000, (timer_done ? result_bits : 3'b000)};
         if (core.wr_en && unlock_reg != flash_seq_pkg::UNLOCK_IDLE) begin
            if ((unlock_reg == flash_seq_pkg::UNLOCK_KEYED && !wr_mode) ||
                (unlock_reg == flash_seq_pkg::UNLOCK_VALUE &&
                 !(wr_mode && core.wdata == ~mode_value_reg)) ||
                (unlock_reg == flash_seq_pkg::UNLOCK_INVERSE &&
                 !(wr_mode && core.wdata == mode_value_reg &&
                   (core.wdata == flash_seq_pkg::MODE_SELF_PROG ||
                    core.wdata == flash_seq_pkg::MODE_NORMAL)))) begin
               status_reg[flash_seq_pkg::STATUS_UNLOCK_BIT] <= 1'b1;
            end
         end
      end
   end

   // halt handshake and erase side effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         halt_ack_reg <= 1'b0;
         erase_strobe <= 1'b0;
         erase_block <= 8'h00;
      end else begin
         erase_strobe <= 1'b0;
         if (timer_load) begin
            busy_reg <= 1'b1;
         end else if (timer_done) begin
            busy_reg <= 1'b0;
            halt_ack_reg <= 1'b1;
            // commands outside self mode do nothing
            if (self_prog_reg && command_reg == flash_seq_pkg::CMD_BLOCK_ERASE &&
                result_bits == 3'b000) begin
               erase_strobe <= 1'b1;
               erase_block <= addr_high_reg;
            end
         end else if (!core.halt_req) begin
            halt_ack_reg <= 1'b0;
         end
      end
   end

   assign core.status = status_reg;
   assign core.self_prog = self_prog_reg;
   assign core.halt_ack = halt_ack_reg;
endmodule

// ### flash_controller.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module flash_controller (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   flash_core_if.core core
);
   typedef enum logic [3:0] {
      C_IDLE = 4'b0000, C_CLR_CMD = 4'b0001, C_CLR_ST = 4'b0010, C_KEY = 4'b0011,
      C_VAL = 4'b0100, C_INV = 4'b0101, C_VAL2 = 4'b0110, C_CHECK = 4'b0111,
      C_SETUP = 4'b1000, C_WDT = 4'b1001, C_HALT = 4'b1010, C_WAIT = 4'b1011,
      C_DONE = 4'b1100
   } ctl_state_type;
   ctl_state_type state_reg;
   logic [1:0] op_reg;
   logic wdt_reg;
   logic busy_reg;
   logic [7:0] block_reg;
   logic [7:0] result_reg;
   logic [5:0] retry_reg;
   logic [2:0] step_reg;
   logic [7:0] mode_val;
   logic apb_wr;

   assign apb_wr = psel && penable && pwrite;
   assign mode_val = (op_reg == flash_seq_pkg::OP_ENTER) ? flash_seq_pkg::MODE_SELF_PROG :
      flash_seq_pkg::MODE_NORMAL;

   // apb slave: zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr > flash_seq_pkg::APB_RESULT;
         case (paddr)
            flash_seq_pkg::APB_CTRL: prdata <= {30'h0, wdt_reg, 1'b0};
            flash_seq_pkg::APB_STATUS: prdata <= {30'h0, core.self_prog, busy_reg};
            flash_seq_pkg::APB_BLOCK: prdata <= {24'h0, block_reg};
            flash_seq_pkg::APB_RESULT: prdata <= {24'h0, result_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // every sequence is issued from this machine, so no step runs from flash under change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= C_IDLE;
         op_reg <= flash_seq_pkg::OP_ENTER;
         wdt_reg <= 1'b0;
         busy_reg <= 1'b0;
         block_reg <= 8'h00;
         result_reg <= 8'h00;
         retry_reg <= 6'h00;
         step_reg <= 3'h0;
         core.wr_en <= 1'b0;
         core.sel <= 4'h0;
         core.wdata <= 8'h00;
         core.halt_req <= 1'b0;
      end else begin
         core.wr_en <= 1'b0;
         case (state_reg)
            C_IDLE: begin
               if (apb_wr && pready && paddr == flash_seq_pkg::APB_BLOCK) begin
                  block_reg <= pwdata[7:0];
               end
               if (apb_wr && pready && paddr == flash_seq_pkg::APB_CTRL) begin
                  wdt_reg <= pwdata[flash_seq_pkg::CTRL_WDT_BIT];
                  if (pwdata[flash_seq_pkg::CTRL_START_BIT]) begin
                     op_reg <= pwdata[3:2];
                     busy_reg <= 1'b1;
                     retry_reg <= 6'(flash_seq_pkg::RETRY_BUDGET);
                     state_reg <= (pwdata[3:2] == flash_seq_pkg::OP_ERASE ||
                        pwdata[3:2] == flash_seq_pkg::OP_BLANK) ? C_SETUP : C_CLR_CMD;
                     step_reg <= 3'h0;
                  end
               end
            end
            C_CLR_CMD: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_FLASH_COMMAND;
               core.wdata <= flash_seq_pkg::CMD_NONE;
               state_reg <= C_CLR_ST;
            end
            C_CLR_ST: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_FLASH_STATUS;
               core.wdata <= 8'h00;
               state_reg <= (op_reg[1]) ? C_WDT : C_KEY;
            end
            C_KEY: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_PROTECT_UNLOCK;
               core.wdata <= flash_seq_pkg::UNLOCK_KEY;
               state_reg <= C_VAL;
            end
            C_VAL: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_MODE_CONTROL;
               core.wdata <= mode_val;
               state_reg <= C_INV;
            end
            C_INV: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_MODE_CONTROL;
               core.wdata <= ~mode_val;
               state_reg <= C_VAL2;
            end
            C_VAL2: begin
               core.wr_en <= 1'b1;
               core.sel <= flash_seq_pkg::SEL_MODE_CONTROL;
               core.wdata <= mode_val;
               state_reg <= C_CHECK;
            end
            C_CHECK: begin
               // status settles one cycle after the last write
               if (step_reg == 3'h1) begin
                  step_reg <= 3'h0;
                  state_reg <= core.status[flash_seq_pkg::STATUS_UNLOCK_BIT] ? C_CLR_ST :
                     C_DONE;
               end else begin
                  step_reg <= step_reg + 3'h1;
               end
            end
            C_SETUP: begin
               // command, pointers and compares loaded one per cycle
               core.wr_en <= 1'b1;
               step_reg <= step_reg + 3'h1;
               case (step_reg)
                  3'h0: begin
                     core.sel <= flash_seq_pkg::SEL_FLASH_COMMAND;
                     core.wdata <= (op_reg == flash_seq_pkg::OP_ERASE) ?
                        flash_seq_pkg::CMD_BLOCK_ERASE : flash_seq_pkg::CMD_BLANK_CHECK;
                  end
                  3'h1: begin
                     core.sel <= flash_seq_pkg::SEL_ADDR_HIGH;
                     core.wdata <= block_reg;
                  end
                  3'h2: begin
                     core.sel <= flash_seq_pkg::SEL_ADDR_LOW;
                     core.wdata <= flash_seq_pkg::LOW_CMP_ERASE;
                  end
                  3'h3: begin
                     core.sel <= flash_seq_pkg::SEL_ADDR_HIGH_CMP;
                     core.wdata <= block_reg;
                  end
                  default: begin
                     core.sel <= flash_seq_pkg::SEL_ADDR_LOW_CMP;
                     core.wdata <= (op_reg == flash_seq_pkg::OP_ERASE) ?
                        flash_seq_pkg::LOW_CMP_ERASE : flash_seq_pkg::LOW_CMP_BLANK;
                     state_reg <= C_CLR_ST;
                  end
               endcase
            end
            C_WDT: begin
               core.wr_en <= wdt_reg;
               core.sel <= flash_seq_pkg::SEL_WATCHDOG;
               core.wdata <= flash_seq_pkg::WATCHDOG_RESTART;
               state_reg <= C_HALT;
            end
            C_HALT: begin
               core.halt_req <= 1'b1;
               if (core.halt_ack) begin
                  core.halt_req <= 1'b0;
                  state_reg <= C_WAIT;
               end
            end
            C_WAIT: begin
               if (!core.halt_ack) begin
                  if (core.status == 8'h00 || op_reg == flash_seq_pkg::OP_BLANK ||
                      core.status[flash_seq_pkg::STATUS_PROTECT_BIT] ||
                      retry_reg == 6'h01) begin
                     state_reg <= C_DONE;
                  end else begin
                     retry_reg <= retry_reg - 6'h01;
                     state_reg <= C_CLR_ST;
                  end
               end
            end
            C_DONE: begin
               result_reg <= core.status;
               busy_reg <= 1'b0;
               state_reg <= C_IDLE;
            end
            default: state_reg <= C_IDLE;
         endcase
      end
   end
endmodule

// ### flash_seq_assertions.sv
`timescale 1ns/1ps
module flash_seq_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [3:0] sel,
   input wire logic [7:0] wdata,
   input wire logic [7:0] status,
   input wire logic self_prog,
   input wire logic halt_req,
   input wire logic halt_ack
);
   logic mode_wr;
   logic key_wr;
   assign mode_wr = wr_en && (sel == flash_seq_pkg::SEL_MODE_CONTROL);
   assign key_wr = wr_en && (sel == flash_seq_pkg::SEL_PROTECT_UNLOCK)
      && (wdata == flash_seq_pkg::UNLOCK_KEY);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_unlock(logic [7:0] v);
      key_wr ##1 (mode_wr && wdata == v) ##1 (mode_wr && wdata == ~v) ##1 (mode_wr && wdata == v);
   endsequence
   property p_enter_applied;
      s_unlock(flash_seq_pkg::MODE_SELF_PROG) |-> ##[1:3] (self_prog && !status[0]);
   endproperty
   property p_leave_applied;
      s_unlock(flash_seq_pkg::MODE_NORMAL) |-> ##[1:3] (!self_prog && !status[0]);
   endproperty
   property p_first_writes_ignored;
      key_wr ##1 mode_wr |=> ($stable(self_prog))[*2];
   endproperty
   property p_mode_needs_write;
      $changed(self_prog) |-> $past(mode_wr) || $past(mode_wr, 2) || $past(mode_wr, 3);
   endproperty
   property p_ack_needs_req;
      $rose(halt_ack) |-> halt_req;
   endproperty
   property p_ack_holds;
      halt_ack && halt_req |=> halt_ack;
   endproperty
   property p_ack_drops;
      !halt_req ##1 !halt_req |-> !halt_ack;
   endproperty
   property p_clear_before_start;
      $rose(halt_req) |-> status == 8'h00;
   endproperty
   property p_normal_refused;
      $rose(halt_req) && !self_prog |-> ##[1:8] (halt_ack && status == 8'h00);
   endproperty
   a_enter_applied: assert property (p_enter_applied)
      else $error("mode entry not applied");
   a_leave_applied: assert property (p_leave_applied)
      else $error("return to normal not applied");
   a_first_writes_ignored: assert property (p_first_writes_ignored)
      else $error("early mode write took effect");
   a_mode_needs_write: assert property (p_mode_needs_write)
      else $error("mode changed without mode write");
   a_ack_needs_req: assert property (p_ack_needs_req)
      else $error("halt ack without request");
   a_ack_holds: assert property (p_ack_holds)
      else $error("halt ack dropped early");
   a_ack_drops: assert property (p_ack_drops)
      else $error("halt ack stuck after release");
   a_clear_before_start: assert property (p_clear_before_start)
      else $error("status not clear at start");
   a_normal_refused: assert property (p_normal_refused)
      else $error("command in normal mode not refused");
endmodule

// ### flash_self_program_sequencer_tb.sv
`timescale 1ns/1ps
module flash_self_program_sequencer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic watchdog_restart;
   logic erase_strobe;
   logic [7:0] erase_block;
   logic [31:0] r;
   logic e;
   logic halt_prev = 1'b0;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int wd_count = 0;
   int es_count = 0;
   int halt_count = 0;
   int h0;
   int wd0;
   always #2.5 pclk = ~pclk;
   flash_core_if flash_core_if_inst ();
   flash_sequencer #(.BLOCKS(32), .PROTECT_BELOW(8'h02), .NOT_BLANK(32'h0000_0040),
      .ERASE_FAIL(32'h0000_0080)) flash_sequencer_inst (.pclk(pclk), .presetn(presetn),
      .core(flash_core_if_inst.device), .watchdog_restart(watchdog_restart),
      .erase_strobe(erase_strobe), .erase_block(erase_block));
   flash_controller flash_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core(flash_core_if_inst.core));
   flash_seq_assertions flash_seq_assertions_inst (.pclk(pclk), .presetn(presetn),
      .wr_en(flash_core_if_inst.wr_en), .sel(flash_core_if_inst.sel),
      .wdata(flash_core_if_inst.wdata), .status(flash_core_if_inst.status),
      .self_prog(flash_core_if_inst.self_prog), .halt_req(flash_core_if_inst.halt_req),
      .halt_ack(flash_core_if_inst.halt_ack));
   // event counters sample before the edge lands, so one-cycle pulses are never missed
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (watchdog_restart === 1'b1) wd_count <= wd_count + 1;
      if (erase_strobe === 1'b1) es_count <= es_count + 1;
      halt_prev <= flash_core_if_inst.halt_req;
      if (flash_core_if_inst.halt_req === 1'b1 && halt_prev === 1'b0) halt_count <= halt_count + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run_op(input logic [1:0] op, input logic wdt);
      int n;
      apb(1'b1, flash_seq_pkg::APB_CTRL, {28'h0, op, wdt, 1'b1});
      n = 0;
      r = 32'h0000_0001;
      // busy is polled rather than timed, the command length is the device's business
      while (r[0] !== 1'b0 && n < 5000) begin
         apb(1'b0, flash_seq_pkg::APB_STATUS, 32'h0);
         n = n + 1;
      end
      if (n >= 5000) begin
         n_errors = n_errors + 1;
         $display("MISMATCH at %0t: busy never cleared", $time);
      end
      apb(1'b0, flash_seq_pkg::APB_RESULT, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, flash_seq_pkg::APB_STATUS, 32'h0);
      chk(r, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      apb(1'b1, flash_seq_pkg::APB_BLOCK, 32'h0000_0005);
      apb(1'b0, flash_seq_pkg::APB_BLOCK, 32'h0);
      chk(r, 32'h0000_0005);
      run_op(flash_seq_pkg::OP_ERASE, 1'b0);
      chk(r, 32'h0000_0000);
      chk(es_count, 0);
      run_op(flash_seq_pkg::OP_ENTER, 1'b0);
      chk(r, 32'h0000_0000);
      apb(1'b0, flash_seq_pkg::APB_STATUS, 32'h0);
      chk(r, 32'h0000_0002);
      wd0 = wd_count;
      run_op(flash_seq_pkg::OP_ERASE, 1'b1);
      chk(r, 32'h0000_0000);
      chk(es_count, 1);
      chk({24'h0, erase_block}, 32'h0000_0005);
      chk(wd_count - wd0, 1);
      apb(1'b0, flash_seq_pkg::APB_CTRL, 32'h0);
      chk(r, 32'h0000_0002);
      for (int b = 5; b <= 6; b++) begin
         apb(1'b1, flash_seq_pkg::APB_BLOCK, b);
         run_op(flash_seq_pkg::OP_BLANK, 1'b0);
         chk(r, (b == 6) ? 32'h0000_0002 : 32'h0000_0000);
      end
      apb(1'b1, flash_seq_pkg::APB_BLOCK, 32'h0000_0001);
      run_op(flash_seq_pkg::OP_ERASE, 1'b0);
      chk(r, 32'h0000_0004);
      chk(es_count, 1);
      apb(1'b1, flash_seq_pkg::APB_BLOCK, 32'h0000_0007);
      h0 = halt_count;
      run_op(flash_seq_pkg::OP_ERASE, 1'b0);
      chk(r, 32'h0000_0002);
      chk(halt_count - h0, flash_seq_pkg::RETRY_BUDGET);
      run_op(flash_seq_pkg::OP_LEAVE, 1'b0);
      chk(r, 32'h0000_0000);
      apb(1'b0, flash_seq_pkg::APB_STATUS, 32'h0);
      chk(r, 32'h0000_0000);
      chk(wd_count, 1);
      wrap_up();
   end
endmodule
